//--- design/wake_map.svh
`ifndef WAKE_MAP_SVH
`define WAKE_MAP_SVH

// ***************************************************************
// register offsets
// ***************************************************************
`define WK_TABLE_OFF     8'h00
`define WK_CTRL_OFF      8'h04

// ***************************************************************
// control and status fields
// ***************************************************************
`define WK_MAGIC_EN_BIT  1
`define WK_PAT_EN_BIT    2
`define WK_MAGIC_SEEN_BIT 4
`define WK_PAT_SEEN_BIT  5
`define WK_NOTIFY_BIT    8
`define WK_PTR_CLR_BIT   9
`define WK_PTR_LSB       16
`define WK_SLEEP_BIT     24
`define WK_DELIVER_BIT   25

// ***************************************************************
// filter table layout
// ***************************************************************
`define WK_CMD_WORD      3'h4
`define WK_OFF_WORD      3'h5
`define WK_CRC_WORD      3'h6
`define WK_CMD_WMASK     32'h0909_0909
`define WK_MASK_WMASK    32'h7FFF_FFFF
`define WK_CMD_ENABLE    0
`define WK_CMD_MCAST     3

// ***************************************************************
// reset values and detection constants
// ***************************************************************
`define WK_RESET_WORD    32'h0000_0000
`define WK_CRC_INIT      16'hFFFF
`define WK_CRC_POLY      16'h8005
`define WK_SYNC_BYTE     8'hFF
`define WK_SYNC_LEN      3'h6
`define WK_LAST_REP      4'hF
`define WK_LAST_ADDR_IDX 3'h5
`define WK_DA_BYTES      9'h006
`define WK_HDR_BYTES     9'h00C
`define WK_MASK_SPAN     9'h01F
`define WK_POS_MAX       9'h1FF

`endif

//--- design/wake_pkg.sv
package wake_pkg;

    typedef enum logic [1:0] {
        M_HUNT,
        M_ADDR,
        M_DONE
    } magic_state_t;

    typedef struct packed {
        logic       valid;
        logic       sof;
        logic       eof;
        logic [7:0] data;
    } rx_byte_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

    typedef struct packed {
        logic [7:0][31:0] filt_tab;
        logic [2:0]       tab_ptr;
        logic             magic_en;
        logic             pat_en;
        logic             notify_pwr;
        logic             magic_seen;
        logic             pat_seen;
        logic [31:0]      rdata;
        logic [8:0]       pos;
        logic [47:0]      dest;
        logic [3:0][15:0] crc;
        magic_state_t     mstate;
        logic [2:0]       ff_cnt;
        logic [3:0]       rep;
        logic [2:0]       bidx;
    } wake_state_t;

endpackage

//--- design/wake_frame_magic_detect.sv
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "wake_map.svh"
// How it works
// RULE1 - set mask bit j folds frame byte offset+j into the filter CRC; bit 31 zero
// RULE2 - command address-type bit picks multicast frames, clear picks unicast frames
// RULE3 - a filter joins recognition only while its enable bit is set; bits 2:1 reserved
// RULE4 - eight-bit offset names first checked byte; zero is first destination byte
// RULE5 - software keeps every pattern offset at twelve or more
// RULE6 - CRC over masked bytes equal to stored pattern CRC means wake frame
// RULE7 - magic enable starts magic detection and suspends normal receive delivery
// RULE8 - detection drives either the host interrupt or the power event output
// RULE9 - magic detection sets the magic seen status bit
// RULE10 - clearing magic enable returns to normal reception
// RULE11 - magic check covers frames to own address or broadcast
// RULE12 - multicast frames also qualify when sixteen address copies are found
// RULE13 - after both address fields search for six consecutive all-ones bytes
// RULE14 - then sixteen back-to-back station address copies are required
// RULE15 - broken repetition restarts the sync search in the rest of frame
// RULE16 - sequence may start anywhere but sync must directly precede copies
// RULE17 - full power needs enable bits; light sleep enables both detectors
// RULE18 - pattern enable suspends receive, match sets pattern seen, clear restores
// RULE19 - four independent filters, each with mask, command, offset, CRC
// RULE20 - software loads the filter table by eight successive port writes
// RULE21 - broadcast wake frame wakes even when broadcast reception is rejected
// RULE22 - all enabled filters are checked; any single match is a wake frame
module wake_frame_magic_detect
    import wake_pkg::*;
(
    input  wire logic        mclk_in,
    input  wire logic        nrst_in,
    input  wire reg_req_t    reg_req_in,
    output logic [31:0]      reg_rdata_out,
    input  wire rx_byte_t    rx_in,
    input  wire logic [47:0] station_addr_in,
    input  wire logic        light_sleep_state_in,
    output logic             rx_deliver_en_out,
    output logic             irq_out,
    output logic             power_event_out
);

    // ***************************************************************
    // helper functions
    // ***************************************************************
    function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        logic        fb;
        r = c;
        for (int k = 7; k >= 0; k--) begin
            fb = r[15] ^ b[k];
            r  = {r[14:0], 1'b0};
            if (fb) begin
                r = r ^ `WK_CRC_POLY;
            end
        end
        return r;
    endfunction

    function automatic logic [7:0] addr_byte(input logic [47:0] a, input logic [2:0] idx);
        logic [47:0] t;
        t = a >> {idx, 3'b000};
        return t[7:0];
    endfunction

    function automatic logic [3:0] filt_cmd(input logic [7:0][31:0] tab, input int i);
        return tab[`WK_CMD_WORD][8*i +: 4];
    endfunction

    function automatic logic [7:0] filt_off(input logic [7:0][31:0] tab, input int i);
        return tab[`WK_OFF_WORD][8*i +: 8];
    endfunction

    function automatic logic [15:0] filt_crc(input logic [7:0][31:0] tab, input int i);
        return tab[`WK_CRC_WORD + 3'(i / 2)][16*(i % 2) +: 16];
    endfunction

    function automatic logic [2:0] ptr_next(input logic [2:0] ptr);
        return ptr + 3'h1;
    endfunction

    function automatic logic mask_hit(input logic [31:0] mask, input logic [8:0] pos,
                                      input logic [7:0] off);
        logic [8:0] r;
        r = pos - {1'b0, off};
        return (pos >= {1'b0, off}) && (r < `WK_MASK_SPAN) && mask[r[4:0]];
    endfunction

    function automatic logic type_match(input logic [3:0] c, input logic mc, input logic own);
        return c[`WK_CMD_MCAST] ? mc : (own && !mc);
    endfunction

    // ***************************************************************
    // reset release
    // ***************************************************************
    logic [1:0]  rst_pipe_ff;
    logic        rst_n;

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_pipe_ff <= 2'h0;
        end else begin
            rst_pipe_ff <= {rst_pipe_ff[0], 1'b1};
        end
    end

    assign rst_n = rst_pipe_ff[1];

    // ***************************************************************
    // state
    // ***************************************************************
    wake_state_t      s_ff;
    wake_state_t      nxt_s;
    logic             magic_act;
    logic             pat_act;
    logic [31:0]      rd_word;
    logic [31:0]      wmask;
    logic             clr_magic;
    logic             clr_pat;
    logic             set_magic;
    logic             set_pat;

    // ***************************************************************
    // frame decode
    // ***************************************************************
    logic [8:0]       p;
    logic [7:0]       b;
    logic [47:0]      dest_v;
    logic [3:0][15:0] crc_v;
    logic [3:0]       cmd;
    logic             is_broadcast_reject;
    logic             is_mcast;
    logic             is_own;
    logic             type_ok;

    // ***************************************************************
    // detector activity
    // ***************************************************************
    // light sleep forces both detectors on
    assign magic_act = s_ff.magic_en | light_sleep_state_in; // RULE17
    assign pat_act   = s_ff.pat_en | light_sleep_state_in; // RULE17

    // ***************************************************************
    // next state
    // ***************************************************************
    always_comb begin
        nxt_s     = s_ff;
        rd_word   = 32'h0000_0000;
        wmask     = 32'hFFFF_FFFF;
        clr_magic = 1'b0;
        clr_pat   = 1'b0;
        set_magic = 1'b0;
        set_pat   = 1'b0;
        p         = 9'h000;
        b         = rx_in.data;
        dest_v    = s_ff.dest;
        crc_v     = s_ff.crc;
        cmd       = 4'h0;
        is_broadcast_reject  = 1'b0;
        is_mcast  = 1'b0;
        is_own    = 1'b0;
        type_ok   = 1'b0;

        // ***********************************************************
        // register port
        // ***********************************************************
        if (s_ff.tab_ptr < `WK_CMD_WORD) begin
            wmask = `WK_MASK_WMASK; // RULE1
        end else if (s_ff.tab_ptr == `WK_CMD_WORD) begin
            wmask = `WK_CMD_WMASK; // RULE3
        end

        if (reg_req_in.wr) begin
            unique case (reg_req_in.addr)
                `WK_TABLE_OFF: begin
                    nxt_s.filt_tab[s_ff.tab_ptr] = reg_req_in.wdata & wmask; // RULE19
                    nxt_s.tab_ptr = ptr_next(s_ff.tab_ptr); // RULE20
                end
                `WK_CTRL_OFF: begin
                    nxt_s.magic_en   = reg_req_in.wdata[`WK_MAGIC_EN_BIT]; // RULE7 RULE10
                    nxt_s.pat_en     = reg_req_in.wdata[`WK_PAT_EN_BIT]; // RULE18
                    nxt_s.notify_pwr = reg_req_in.wdata[`WK_NOTIFY_BIT]; // RULE8
                    clr_magic        = reg_req_in.wdata[`WK_MAGIC_SEEN_BIT];
                    clr_pat          = reg_req_in.wdata[`WK_PAT_SEEN_BIT];
                    if (reg_req_in.wdata[`WK_PTR_CLR_BIT]) begin
                        nxt_s.tab_ptr = 3'h0;
                    end
                end
                default: begin
                end
            endcase
        end

        unique case (reg_req_in.addr)
            `WK_TABLE_OFF: begin
                rd_word = s_ff.filt_tab[s_ff.tab_ptr];
            end
            `WK_CTRL_OFF: begin
                rd_word[`WK_MAGIC_EN_BIT]   = s_ff.magic_en;
                rd_word[`WK_PAT_EN_BIT]     = s_ff.pat_en;
                rd_word[`WK_MAGIC_SEEN_BIT] = s_ff.magic_seen;
                rd_word[`WK_PAT_SEEN_BIT]   = s_ff.pat_seen;
                rd_word[`WK_NOTIFY_BIT]     = s_ff.notify_pwr;
                rd_word[`WK_PTR_LSB +: 3]   = s_ff.tab_ptr;
                rd_word[`WK_SLEEP_BIT]      = light_sleep_state_in;
                rd_word[`WK_DELIVER_BIT]    = ~(magic_act | pat_act);
            end
            default: begin
                rd_word = 32'h0000_0000;
            end
        endcase

        nxt_s.rdata = reg_req_in.rd ? rd_word : 32'h0000_0000;
        if (reg_req_in.rd && reg_req_in.addr == `WK_TABLE_OFF) begin
            nxt_s.tab_ptr = ptr_next(s_ff.tab_ptr); // RULE20
        end

        // ***********************************************************
        // frame byte processing
        // ***********************************************************
        if (rx_in.valid) begin
            p = rx_in.sof ? 9'h000 : s_ff.pos;
            nxt_s.pos = (p == `WK_POS_MAX) ? p : p + 9'h001;

            if (rx_in.sof) begin
                crc_v        = {4{`WK_CRC_INIT}};
                nxt_s.mstate = M_HUNT;
                nxt_s.ff_cnt = 3'h0;
                nxt_s.rep    = 4'h0;
                nxt_s.bidx   = 3'h0;
            end

            if (p < `WK_DA_BYTES) begin
                dest_v[{p[2:0], 3'b000} +: 8] = b; // RULE4
            end
            nxt_s.dest = dest_v;

            // ***********************************************************
            // masked crc per filter
            // ***********************************************************
            for (int i = 0; i < 4; i++) begin
                if (mask_hit(s_ff.filt_tab[i], p, filt_off(s_ff.filt_tab, i))) begin // RULE4
                    crc_v[i] = crc16_byte(crc_v[i], b); // RULE1
                end
            end
            nxt_s.crc = crc_v;

            // ***********************************************************
            // magic sequence search past both address fields
            // ***********************************************************
            if (p >= `WK_HDR_BYTES) begin // RULE13
                unique case (nxt_s.mstate)
                    M_HUNT: begin
                        if (nxt_s.ff_cnt == `WK_SYNC_LEN &&
                            b == addr_byte(station_addr_in, 3'h0)) begin
                            nxt_s.mstate = M_ADDR; // RULE16
                            nxt_s.bidx   = 3'h1;
                            nxt_s.rep    = 4'h0;
                        end else if (b == `WK_SYNC_BYTE) begin
                            if (nxt_s.ff_cnt != `WK_SYNC_LEN) begin
                                nxt_s.ff_cnt = nxt_s.ff_cnt + 3'h1; // RULE13
                            end
                        end else begin
                            nxt_s.ff_cnt = 3'h0;
                        end
                    end
                    M_ADDR: begin
                        if (b == addr_byte(station_addr_in, nxt_s.bidx)) begin // RULE14
                            if (nxt_s.bidx == `WK_LAST_ADDR_IDX) begin
                                nxt_s.bidx = 3'h0;
                                if (nxt_s.rep == `WK_LAST_REP) begin
                                    nxt_s.mstate = M_DONE; // RULE14
                                end else begin
                                    nxt_s.rep = nxt_s.rep + 4'h1;
                                end
                            end else begin
                                nxt_s.bidx = nxt_s.bidx + 3'h1;
                            end
                        end else begin
                            nxt_s.mstate = M_HUNT; // RULE15
                            nxt_s.ff_cnt = (b == `WK_SYNC_BYTE) ? 3'h1 : 3'h0; // RULE15
                        end
                    end
                    M_DONE: begin
                    end
                    default: begin
                        nxt_s.mstate = M_HUNT;
                        nxt_s.ff_cnt = 3'h0;
                    end
                endcase
            end

            // ***********************************************************
            // end of frame decisions
            // ***********************************************************
            if (rx_in.eof) begin
                is_broadcast_reject = &dest_v;
                is_mcast = dest_v[0];
                is_own   = (dest_v == station_addr_in);

                if (magic_act && nxt_s.mstate == M_DONE &&
                    (is_own || is_broadcast_reject || is_mcast)) begin // RULE11 RULE12
                    set_magic = 1'b1; // RULE9
                end

                for (int i = 0; i < 4; i++) begin
                    cmd = filt_cmd(s_ff.filt_tab, i);
                    // broadcast counts as multicast; reject setting not consulted
                    type_ok = type_match(cmd, is_mcast, is_own); // RULE2 RULE21
                    if (pat_act && cmd[`WK_CMD_ENABLE] && type_ok && // RULE3
                        crc_v[i] == filt_crc(s_ff.filt_tab, i)) begin // RULE6
                        set_pat = 1'b1; // RULE22
                    end
                end
            end
        end

        // ***********************************************************
        // status flags
        // ***********************************************************
        // set wins over a same-cycle clear
        nxt_s.magic_seen = (s_ff.magic_seen & ~clr_magic) | set_magic; // RULE9
        nxt_s.pat_seen   = (s_ff.pat_seen & ~clr_pat) | set_pat; // RULE18
    end

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ***************************************************************
    // outputs
    // ***************************************************************
    assign reg_rdata_out     = s_ff.rdata;
    assign rx_deliver_en_out = ~(magic_act | pat_act); // RULE7 RULE10 RULE18
    assign irq_out           = ~s_ff.notify_pwr & (s_ff.magic_seen | s_ff.pat_seen); // RULE8
    assign power_event_out   = s_ff.notify_pwr & (s_ff.magic_seen | s_ff.pat_seen); // RULE8

endmodule

//--- verification/wake_sva.sv
`timescale 1ns/1ps
module wake_sva
    import wake_pkg::*;
(
    input wire logic        mclk_in,
    input wire logic        nrst_in,
    input wire reg_req_t    reg_req_in,
    input wire logic [31:0] reg_rdata_out,
    input wire rx_byte_t    rx_in,
    input wire logic [47:0] station_addr_in,
    input wire logic        light_sleep_state_in,
    input wire logic        rx_deliver_en_out,
    input wire logic        irq_out,
    input wire logic        power_event_out
);
    // ****
    // register port and event checks
    // ****
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!nrst_in);
    a_rdata_idle: assert property (!$past(reg_req_in.rd) |-> reg_rdata_out == '0)
        else $error("read data outside its slot");
    a_unmapped_zero: assert property ($past(reg_req_in.rd && reg_req_in.addr != 8'h00
        && reg_req_in.addr != 8'h04) |-> reg_rdata_out == '0)
        else $error("unmapped read not zero");
    a_notify_excl: assert property (!(irq_out && power_event_out))
        else $error("both notify outputs high");
    a_deliver_sleep: assert property (light_sleep_state_in |-> !rx_deliver_en_out)
        else $error("delivery on in light sleep");
    a_irq_hold: assert property (irq_out && !(reg_req_in.wr && reg_req_in.addr == 8'h04)
        |=> irq_out)
        else $error("irq dropped without status write");
    a_pwr_hold: assert property (power_event_out
        && !(reg_req_in.wr && reg_req_in.addr == 8'h04) |=> power_event_out)
        else $error("power event dropped without status write");
    a_event_cause: assert property ($rose(irq_out || power_event_out)
        |-> $past(rx_in.valid && rx_in.eof))
        else $error("notify rose without frame end");
    a_stat_irq: assert property ($past(reg_req_in.rd && reg_req_in.addr == 8'h04)
        |-> ((reg_rdata_out[4] || reg_rdata_out[5]) && !reg_rdata_out[8]) == $past(irq_out))
        else $error("status disagrees with irq");
    a_stat_deliver: assert property ($past(reg_req_in.rd && reg_req_in.addr == 8'h04)
        |-> reg_rdata_out[25] == $past(rx_deliver_en_out)
        && reg_rdata_out[24] == $past(light_sleep_state_in))
        else $error("status disagrees with delivery");
endmodule

bind wake_frame_magic_detect wake_sva chk_i (.mclk_in(mclk_in), .nrst_in(nrst_in),
    .reg_req_in(reg_req_in), .reg_rdata_out(reg_rdata_out), .rx_in(rx_in),
    .station_addr_in(station_addr_in), .light_sleep_state_in(light_sleep_state_in),
    .rx_deliver_en_out(rx_deliver_en_out), .irq_out(irq_out),
    .power_event_out(power_event_out));

//--- verification/frame_src.sv
`timescale 1ns/1ps
module frame_src
    import wake_pkg::*;
(
    input  wire logic mclk_in,
    output rx_byte_t  rx_out
);
    logic [7:0] frm [0:199];
    initial rx_out = '0;
    // ****
    // one frame, gap idle cycles after each byte
    // ****
    task automatic send(input int len, input int gap);
        for (int i = 0; i < len; i++) begin
            @(posedge mclk_in);
            rx_out <= '{1'b1, i == 0, i == len - 1, frm[i]};
            repeat (gap) begin
                @(posedge mclk_in);
                rx_out <= '{1'b0, 1'b0, 1'b0, ~frm[i]};
            end
        end
        @(posedge mclk_in);
        rx_out <= '{1'b0, 1'b0, 1'b0, ~frm[len - 1]};
    endtask
endmodule

//--- verification/wake_frame_magic_detect_tb.sv
`timescale 1ns/1ps
module wake_frame_magic_detect_tb
    import wake_pkg::*;
    ();
    logic        mclk_in = 1'b0;
    logic        nrst_in = 1'b0;
    reg_req_t    req = '0;
    logic [31:0] rdata;
    rx_byte_t    rx;
    logic [47:0] sta = 48'h5544_3322_1100;
    logic        sleep = 1'b0;
    logic        deliver;
    logic        irq;
    logic        pev;
    logic [31:0] rdv;
    logic [31:0] w [0:7];
    int          len;
    int          failures = 0;
    int          samples_checked = 0;
    logic [47:0] das [0:3] = '{48'h5544_3322_1100, 48'h0000_5E00_0001,
                               48'hFFFF_FFFF_FFFF, 48'h5544_3322_1102};
    int          pc [0:5][0:2] = '{'{0, 0, 1}, '{1, 0, 1}, '{3, 0, 0}, '{1, 14, 0},
                                   '{0, 13, 1}, '{2, 0, 1}};
    int          mc [0:5][0:3] = '{'{0, 0, 16, 1}, '{2, 3, 16, 1}, '{1, 0, 16, 1},
                                   '{3, 0, 16, 0}, '{0, 0, 15, 0}, '{0, 15, 1, 0}};
    always #50 mclk_in = ~mclk_in;
    wake_frame_magic_detect dut (.mclk_in(mclk_in), .nrst_in(nrst_in), .reg_req_in(req),
        .reg_rdata_out(rdata), .rx_in(rx), .station_addr_in(sta),
        .light_sleep_state_in(sleep), .rx_deliver_en_out(deliver), .irq_out(irq),
        .power_event_out(pev));
    frame_src src (.mclk_in(mclk_in), .rx_out(rx));
    // ****
    // access tasks
    // ****
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge mclk_in);
        req <= '0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge mclk_in);
        req <= '{a, 32'h0000_0000, 1'b0, 1'b1};
        @(posedge mclk_in);
        req <= '0;
        #1 rdv = rdata;
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ****
    // frame builders and reference crc
    // ****
    function automatic logic [15:0] crcm(input int off, input logic [30:0] m);
        logic [15:0] c;
        c = 16'hFFFF;
        for (int j = 0; j < 31; j++)
            if (m[j])
                for (int k = 7; k >= 0; k--)
                    c = {c[14:0], 1'b0} ^ ((c[15] ^ src.frm[off + j][k]) ? 16'h8005 : 16'h0000);
        return c;
    endfunction
    task automatic mkp(input logic [47:0] da, input int flip);
        for (int k = 0; k < 64; k++) src.frm[k] = k < 6 ? da[8*k+:8] : k[7:0];
        if (flip > 0) src.frm[flip] ^= 8'h80;
    endtask
    task automatic put(inout int p, input int c);
        for (int r = 0; r < 6 + 6 * c; r++) src.frm[p + r] = r < 6 ? 8'hFF : sta[8*((r-6)%6)+:8];
        p += 6 + 6 * c;
    endtask
    task automatic mkm(input logic [47:0] da, input int first, input int n, output int l);
        for (int k = 0; k < 13; k++) src.frm[k] = k < 6 ? da[8*k+:8] : 8'h33;
        l = 13;
        if (first > 0) begin
            put(l, first);
            src.frm[l++] = 8'h33;
        end
        put(l, n);
        src.frm[l++] = 8'h33;
    endtask
    // ****
    // test sequence
    // ****
    initial begin
        repeat (10) @(posedge mclk_in);
        nrst_in <= 1'b1;
        repeat (3) @(posedge mclk_in);
        rd(8'h04);
        chk("ctrl reset", 32'h0200_0000, rdv);
        rd(8'h08);
        chk("unmapped", 32'h0000_0000, rdv);
        mkp(sta, 0);
        w = '{32'h8000_000F, 32'h0000_0003, 32'h0000_0001, 32'h4000_0000,
              32'h010E_0F01, 32'h1410_0E0C, {crcm(14, 3), crcm(12, 15)},
              {crcm(20, 31'h4000_0000), crcm(16, 1)}};
        wr(8'h04, 32'h0000_0200);
        for (int i = 0; i < 8; i++) wr(8'h00, w[i]);
        wr(8'h04, 32'h0000_0200);
        for (int i = 0; i < 8; i++) begin
            rd(8'h00);
            chk("table", w[i] & (i < 4 ? 32'h7FFF_FFFF : i == 4 ? 32'h0909_0909 : '1), rdv);
        end
        wr(8'h04, 32'h0000_0004);
        #1 chk("deliver off", 32'h0, deliver);
        for (int i = 0; i < 6; i++) begin
            mkp(das[pc[i][0]], pc[i][1]);
            src.send(64, i % 2);
            rd(8'h04);
            chk("pattern seen", pc[i][2], rdv[5]);
            chk("pattern irq", pc[i][2], irq);
            wr(8'h04, 32'h0000_0024);
        end
        wr(8'h04, 32'h0000_0000);
        mkp(sta, 0);
        src.send(64, 0);
        rd(8'h04);
        chk("disabled", 32'h0200_0000, rdv);
        for (int i = 0; i < 6; i++) begin
            mkm(das[mc[i][0]], mc[i][1], mc[i][2], len);
            wr(8'h04, 32'h0000_0002 | (i % 2) << 8);
            #1 chk("magic deliver", 32'h0, deliver);
            src.send(len, i % 2);
            rd(8'h04);
            chk("magic seen", mc[i][3], rdv[4]);
            chk("irq", mc[i][3] == 1 && i % 2 == 0, irq);
            chk("power event", mc[i][3] == 1 && i % 2 == 1, pev);
            wr(8'h04, 32'h0000_0012);
        end
        wr(8'h04, 32'h0000_0000);
        #1 chk("deliver on", 32'h1, deliver);
        @(posedge mclk_in);
        sleep <= 1'b1;
        mkm(das[0], 0, 16, len);
        src.send(len, 0);
        rd(8'h04);
        chk("sleep status", 32'h0100_0010, rdv & 32'h0300_0010);
        chk("sleep deliver", 32'h0, deliver);
        report_and_stop();
    end
    initial begin
        repeat (30000) @(posedge mclk_in);
        failures++;
        report_and_stop();
    end
endmodule
